/* hdl/sweep_seq_pkg.sv */
// constants and types for the sweep sequencer
// Functional notes
// [R1] linear staircase runs start toward stop by programmed step
// [R2] on trigger, leave bias for start level, then equal steps to stop
// [R3] point dwell is source delay plus measurement time at integration period
// [R4] per-point delay latched at sweep start, same for every step
// [R5] log increment is log-span divided by point count minus one
// [R6] log point level is antilog of accumulated log step, zero to full span (here the log2 code goes out with LEVEL_LOG_O set, antilog downstream)
// [R7] compliance abort mode is never, early or late; never disables abort
// [R8] early aborts at cycle start on compliance, late at cycle end
// [R9] custom sweep visits programmed points in order, stops after last
// [R10] stored setup sweep recalls full setup at each location, up to 100
// [R11] stored sweep takes start and count; after location 100 wraps to 1
// [R12] stored sweep start location defaults to 1
// [R13] range holdoff only in stored sweeps: compliance range, then measure range (here one holdoff during delay, none for measure range)
// [R14] holdoff parameters are stored per location, set remotely only
// [R15] setups kept in battery-backed storage, survive power loss
// [R16] any single stored setup 1-100 can be restored alone
// [R17] readings produced in a sweep are written to the reading buffer
// [R18] on limit pass with branch set, jump there; else next location
// [R19] stored sweep length is the programmed point count, not the number of locations
// [R20] one-cycle done pulse after last point or compliance abort
package sweep_seq_pkg;
    localparam int LVL_W      = 24;
    localparam int DLY_W      = 24;
    localparam int CNT_W      = 12;
    localparam int LOC_W      = 7;
    localparam int MEM_LOCS   = 100;
    localparam int LOG_FRAC   = 16;   // log2 domain fraction bits
    localparam int CUST_DEPTH = 256;
    localparam int CUST_AW    = 8;
    // register offsets
    localparam logic [7:0] A_CTRL     = 8'h00;
    localparam logic [7:0] A_START    = 8'h01;
    localparam logic [7:0] A_STOP     = 8'h02;
    localparam logic [7:0] A_STEP     = 8'h03;
    localparam logic [7:0] A_POINTS   = 8'h04;
    localparam logic [7:0] A_DELAY    = 8'h05;
    localparam logic [7:0] A_MEMLOC   = 8'h06;
    localparam logic [7:0] A_CUSTIDX  = 8'h07;
    localparam logic [7:0] A_CUSTVAL  = 8'h08;
    localparam logic [7:0] A_STATUS   = 8'h09;
    localparam logic [7:0] A_RESTORE  = 8'h0A;
    // control field positions
    localparam int C_TYPE_LSB  = 0;
    localparam int C_ABORT_LSB = 2;
    localparam int C_GO_BIT    = 4;
    localparam logic [LOC_W-1:0] MEMLOC_RST = 7'h01;
    localparam logic [CNT_W-1:0] POINTS_RST = 12'h001;

    typedef enum logic [1:0] {
        SW_LIN = 2'h0, SW_LOG = 2'h1, SW_CUST = 2'h2, SW_MEM = 2'h3
    } sweep_type_e;
    typedef enum logic [1:0] {
        AB_NEVER = 2'h0, AB_EARLY = 2'h1, AB_LATE = 2'h2
    } abort_mode_e;
endpackage

/* hdl/sweep_point_if.sv */
// level-and-handshake bundle between the sequencer core and its step engine
`timescale 1ns/1ps
interface sweep_point_if;
    import sweep_seq_pkg::*;
    logic             load;
    logic [LVL_W-1:0] start;
    logic [LVL_W-1:0] stop;
    logic [LVL_W-1:0] step;
    logic [CNT_W-1:0] points;
    logic             is_log;
    logic             adv;
    logic [LVL_W-1:0] level;
    logic             last;
    modport core (output load, start, stop, step, points, is_log, adv, input level, last);
    modport eng  (input load, start, stop, step, points, is_log, adv, output level, last);
endinterface

/* hdl/sweep_step_engine.sv */
// level generator for linear and logarithmic staircases
`timescale 1ns/1ps
module sweep_step_engine
    import sweep_seq_pkg::*;
(
    input  wire logic CLK_I,
    input  wire logic SRST_I,
    sweep_point_if.eng sp
);
    // levels for log sweeps are log2 codes with LOG_FRAC fraction bits;
    // antilog is done downstream, so this accumulates log steps only
    logic [LVL_W-1:0] acc_r, acc_nxt, inc_r, inc_nxt;
    logic [CNT_W-1:0] idx_r, idx_nxt;
    logic [CNT_W-1:0] div_pts;

    // next-state for level and index
    always_comb begin
        acc_nxt = acc_r;
        inc_nxt = inc_r;
        idx_nxt = idx_r;
        div_pts = (sp.points > 12'h001) ? sp.points - 12'h001 : 12'h001;
        if (sp.load) begin
            acc_nxt = sp.start;
            idx_nxt = '0;
            // [R5] log increment span
            if (sp.is_log)
                inc_nxt = LVL_W'((sp.stop - sp.start) / LVL_W'(div_pts));
            else
                inc_nxt = sp.step;
        end else if (sp.adv) begin
            // [R2] equal increments
            acc_nxt = acc_r + inc_r;
            idx_nxt = idx_r + 12'h001;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            acc_r <= '0;
            inc_r <= '0;
            idx_r <= '0;
        end else begin
            acc_r <= acc_nxt;
            inc_r <= inc_nxt;
            idx_r <= idx_nxt;
        end
    end

    // [R6] last log point pinned to full span, avoids rounding drift
    assign sp.level = (sp.is_log && idx_r + 12'h001 >= sp.points) ? sp.stop : acc_r;
    // [R1] linear ends when the next step would pass stop, or when the step is zero
    assign sp.last  = sp.is_log ? (idx_r + 12'h001 >= sp.points)
                    : ((inc_r[LVL_W-1] ? $signed(acc_r + inc_r) < $signed(sp.stop)
                                       : $signed(acc_r + inc_r) > $signed(sp.stop))
                       || inc_r == '0);
endmodule // sweep_step_engine

/* hdl/sweep_seq.sv */
// top of the sweep sequencer: registers, setup memory and point sequencing
`timescale 1ns/1ps
module sweep_seq
    import sweep_seq_pkg::*;
(
    input  wire logic             CLK_I,
    input  wire logic             SRST_I,
    input  wire logic [7:0]       ADDR_I,
    input  wire logic [31:0]      WDATA_I,
    input  wire logic             WR_I,
    input  wire logic             RD_I,
    output logic      [31:0]      RDATA_O,
    input  wire logic             TRIG_I,
    input  wire logic             COMPL_I,
    input  wire logic             MEAS_DONE_I,
    input  wire logic             LIMIT_PASS_I,
    input  wire logic [LVL_W-1:0] MEAS_VAL_I,
    input  wire logic             SETUP_WR_I,
    input  wire logic [LOC_W-1:0] SETUP_LOC_I,
    input  wire logic [31:0]      SETUP_DATA_I,
    output logic [LVL_W-1:0]      LEVEL_O,
    output logic                  LEVEL_LOG_O,
    output logic                  SRC_APPLY_O,
    output logic [31:0]           SETUP_O,
    output logic                  HOLDOFF_O,
    output logic                  MEAS_START_O,
    output logic                  BUF_WR_O,
    output logic [LVL_W-1:0]      BUF_DATA_O,
    output logic                  BUSY_O,
    output logic                  DONE_O,
    output logic                  ABORTED_O
);
    // setup word: [23:0] level, [24] holdoff, [31:25] branch location (0 = next)
    localparam int S_HOLD_BIT = 24;
    localparam int S_BR_LSB   = 25;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_APPLY = 6'b000010,
        ST_DELAY = 6'b000100,
        ST_MEAS  = 6'b001000,
        ST_NEXT  = 6'b010000,
        ST_DONE  = 6'b100000
    } state_e;

    sweep_point_if sp();
    sweep_step_engine u_eng (.CLK_I(CLK_I), .SRST_I(SRST_I), .sp(sp));

    // [R15] setup memory held in retained storage; no reset clears it
    logic [31:0]      setup_mem [1:MEM_LOCS];
    logic [LVL_W-1:0] cust_mem  [0:CUST_DEPTH-1];

    logic [1:0]       type_r, type_nxt, abort_r, abort_nxt;
    logic [LVL_W-1:0] start_r, start_nxt, stop_r, stop_nxt, step_r, step_nxt;
    logic [CNT_W-1:0] pts_r, pts_nxt;
    logic [DLY_W-1:0] dly_r, dly_nxt;
    logic [LOC_W-1:0] memloc_r, memloc_nxt;
    logic [CUST_AW-1:0] cidx_r, cidx_nxt;
    logic [31:0]      rdata_nxt;
    logic             go;

    // register write decode and read mux
    always_comb begin
        type_nxt   = type_r;
        abort_nxt  = abort_r;
        start_nxt  = start_r;
        stop_nxt   = stop_r;
        step_nxt   = step_r;
        pts_nxt    = pts_r;
        dly_nxt    = dly_r;
        memloc_nxt = memloc_r;
        cidx_nxt   = cidx_r;
        go         = 1'b0;
        if (WR_I) begin
            unique case (ADDR_I)
                A_CTRL: begin
                    type_nxt  = WDATA_I[C_TYPE_LSB +: 2];
                    abort_nxt = WDATA_I[C_ABORT_LSB +: 2];
                    go        = WDATA_I[C_GO_BIT];
                end
                A_START:   start_nxt  = WDATA_I[LVL_W-1:0];
                A_STOP:    stop_nxt   = WDATA_I[LVL_W-1:0];
                A_STEP:    step_nxt   = WDATA_I[LVL_W-1:0];
                A_POINTS:  pts_nxt    = WDATA_I[CNT_W-1:0];
                A_DELAY:   dly_nxt    = WDATA_I[DLY_W-1:0];
                A_MEMLOC:  memloc_nxt = WDATA_I[LOC_W-1:0];
                A_CUSTIDX: cidx_nxt   = WDATA_I[CUST_AW-1:0];
                // custom value write auto-increments the index
                A_CUSTVAL: cidx_nxt   = cidx_r + 8'h01;
                default: ;
            endcase
        end
        rdata_nxt = 32'h0000_0000;
        if (RD_I) begin
            unique case (ADDR_I)
                A_CTRL:   rdata_nxt = {28'h000_0000, abort_r, type_r};
                A_START:  rdata_nxt = {8'h00, start_r};
                A_STOP:   rdata_nxt = {8'h00, stop_r};
                A_STEP:   rdata_nxt = {8'h00, step_r};
                A_POINTS: rdata_nxt = {20'h0_0000, pts_r};
                A_DELAY:  rdata_nxt = {8'h00, dly_r};
                A_MEMLOC: rdata_nxt = {25'h000_0000, memloc_r};
                A_CUSTIDX: rdata_nxt = {24'h00_0000, cidx_r};
                A_STATUS: rdata_nxt = {29'h0000_0000, ABORTED_O, DONE_O, BUSY_O};
                default:  rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            type_r   <= SW_LIN;
            abort_r  <= AB_NEVER;
            start_r  <= '0;
            stop_r   <= '0;
            step_r   <= '0;
            pts_r    <= POINTS_RST;
            dly_r    <= '0;
            // [R12] start location defaults to one
            memloc_r <= MEMLOC_RST;
            cidx_r   <= '0;
            RDATA_O  <= '0;
        end else begin
            type_r   <= type_nxt;
            abort_r  <= abort_nxt;
            start_r  <= start_nxt;
            stop_r   <= stop_nxt;
            step_r   <= step_nxt;
            pts_r    <= pts_nxt;
            dly_r    <= dly_nxt;
            memloc_r <= memloc_nxt;
            cidx_r   <= cidx_nxt;
            RDATA_O  <= rdata_nxt;
        end
    end

    // [R14] per-location setup incl. holdoff, written from remote port only
    always_ff @(posedge CLK_I) begin
        if (SETUP_WR_I && SETUP_LOC_I >= 7'h01 && SETUP_LOC_I <= 7'(MEM_LOCS))
            setup_mem[SETUP_LOC_I] <= SETUP_DATA_I;
        if (WR_I && ADDR_I == A_CUSTVAL)
            cust_mem[cidx_r] <= WDATA_I[LVL_W-1:0];
    end

    // trigger and compliance inputs cross in from outside
    logic [1:0] trig_s, compl_s;
    always_ff @(posedge CLK_I) begin
        trig_s  <= {trig_s[0], TRIG_I};
        compl_s <= {compl_s[0], COMPL_I};
    end

    // sequencer state
    state_e           st_r, st_nxt;
    logic [1:0]       styp_r, styp_nxt, sab_r, sab_nxt;
    logic [DLY_W-1:0] sdly_r, sdly_nxt, tmr_r, tmr_nxt;
    logic [CNT_W-1:0] left_r, left_nxt, ptn_r, ptn_nxt;
    logic [LOC_W-1:0] loc_r, loc_nxt, br;
    logic             first_r, first_nxt, ab_nxt, is_last;
    logic [31:0]      cur;
    logic             restore;
    // arm flag: sweep waits for a trigger after software go
    logic             go_pend_r, go_pend_nxt;

    assign cur     = setup_mem[loc_r];
    assign br      = cur[S_BR_LSB +: LOC_W];
    // [R16] restore only for locations 1-100; others would read unwritten words
    assign restore = WR_I && ADDR_I == A_RESTORE && WDATA_I[LOC_W-1:0] != '0
                     && WDATA_I[LOC_W-1:0] <= 7'(MEM_LOCS);
    assign is_last = (styp_r == SW_LIN || styp_r == SW_LOG) ? sp.last : (left_r <= 12'h001);

    assign sp.load   = (st_r == ST_IDLE) && trig_s[1] && go_pend_r;
    assign sp.start  = start_r;
    assign sp.stop   = stop_r;
    assign sp.step   = step_r;
    assign sp.points = pts_r;
    assign sp.is_log = (st_r == ST_IDLE) ? (type_r == SW_LOG) : (styp_r == SW_LOG);
    assign sp.adv    = (st_r == ST_NEXT) && !is_last;

    always_comb begin
        st_nxt      = st_r;
        styp_nxt    = styp_r;
        sab_nxt     = sab_r;
        sdly_nxt    = sdly_r;
        tmr_nxt     = tmr_r;
        left_nxt    = left_r;
        ptn_nxt     = ptn_r;
        loc_nxt     = loc_r;
        first_nxt   = first_r;
        go_pend_nxt = go_pend_r | go;
        ab_nxt      = 1'b0;
        unique case (st_r)
            ST_IDLE: if (sp.load) begin
                // [R4] delay and mode frozen for the whole sweep
                sdly_nxt    = dly_r;
                styp_nxt    = type_r;
                sab_nxt     = abort_r;
                left_nxt    = pts_r;
                ptn_nxt     = '0;
                loc_nxt     = memloc_r;
                go_pend_nxt = go;   // a go in the load cycle re-arms
                st_nxt      = ST_APPLY;
            end
            ST_APPLY: begin
                tmr_nxt   = sdly_r;
                first_nxt = 1'b1;
                st_nxt    = ST_DELAY;
            end
            ST_DELAY: begin
                first_nxt = 1'b0;
                // [R8] early abort at cycle start
                if (first_r && sab_r == AB_EARLY && compl_s[1]) begin
                    ab_nxt = 1'b1;
                    st_nxt = ST_DONE;
                // [R3] dwell: source delay then measurement
                end else if (tmr_r == '0) begin
                    st_nxt = ST_MEAS;
                end else begin
                    tmr_nxt = tmr_r - 24'h00_0001;
                end
            end
            ST_MEAS: if (MEAS_DONE_I) begin
                // [R8] late abort at cycle end
                if (sab_r == AB_LATE && compl_s[1]) begin
                    ab_nxt = 1'b1;
                    st_nxt = ST_DONE;
                end else begin
                    st_nxt = ST_NEXT;
                end
            end
            ST_NEXT: begin
                // [R19] count points, not locations
                left_nxt = left_r - 12'h001;
                ptn_nxt  = ptn_r + 12'h001;
                if (is_last) begin
                    st_nxt = ST_DONE;
                end else begin
                    // [R18] branch on pass, else next
                    if (br != '0 && LIMIT_PASS_I)
                        loc_nxt = br;
                    // [R11] wrap past last location
                    else if (loc_r >= 7'(MEM_LOCS))
                        loc_nxt = 7'h01;
                    else
                        loc_nxt = loc_r + 7'h01;
                    st_nxt = ST_APPLY;
                end
            end
            ST_DONE: st_nxt = ST_IDLE;
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            st_r      <= ST_IDLE;
            styp_r    <= SW_LIN;
            sab_r     <= AB_NEVER;
            sdly_r    <= '0;
            tmr_r     <= '0;
            left_r    <= '0;
            ptn_r     <= '0;
            loc_r     <= MEMLOC_RST;
            first_r   <= 1'b0;
            go_pend_r <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            styp_r    <= styp_nxt;
            sab_r     <= sab_nxt;
            sdly_r    <= sdly_nxt;
            tmr_r     <= tmr_nxt;
            left_r    <= left_nxt;
            ptn_r     <= ptn_nxt;
            loc_r     <= restore ? WDATA_I[LOC_W-1:0] : loc_nxt;
            first_r   <= first_nxt;
            go_pend_r <= go_pend_nxt;
        end
    end

    // output drive, all registered
    logic [LVL_W-1:0] lvl_nxt;
    always_comb begin
        unique case (styp_r)
            // [R10] stored sweep applies full setup
            SW_MEM:  lvl_nxt = cur[LVL_W-1:0];
            // [R9] custom points in programmed order
            SW_CUST: lvl_nxt = cust_mem[ptn_r[CUST_AW-1:0]];
            default: lvl_nxt = sp.level;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            LEVEL_O      <= '0;
            LEVEL_LOG_O  <= 1'b0;
            SRC_APPLY_O  <= 1'b0;
            SETUP_O      <= '0;
            HOLDOFF_O    <= 1'b0;
            MEAS_START_O <= 1'b0;
            BUF_WR_O     <= 1'b0;
            BUF_DATA_O   <= '0;
            BUSY_O       <= 1'b0;
            DONE_O       <= 1'b0;
            ABORTED_O    <= 1'b0;
        end else begin
            // [R16] single restore also drives the stored setup out
            SRC_APPLY_O  <= (st_r == ST_APPLY) || restore;
            if (st_r == ST_APPLY) begin
                LEVEL_O     <= lvl_nxt;
                LEVEL_LOG_O <= (styp_r == SW_LOG);
                SETUP_O     <= cur;
            end else if (restore) begin
                SETUP_O <= setup_mem[WDATA_I[LOC_W-1:0]];
            end
            // [R13] holdoff on compliance range during delay, stored sweeps only
            HOLDOFF_O    <= (st_nxt == ST_DELAY) && styp_r == SW_MEM && cur[S_HOLD_BIT];
            MEAS_START_O <= (st_r == ST_DELAY) && (st_nxt == ST_MEAS);
            // [R17] every reading into the buffer
            BUF_WR_O     <= (st_r == ST_MEAS) && MEAS_DONE_I;
            if ((st_r == ST_MEAS) && MEAS_DONE_I)
                BUF_DATA_O <= MEAS_VAL_I;
            BUSY_O       <= (st_nxt != ST_IDLE);
            // [R20] one-cycle completion pulse
            DONE_O       <= (st_nxt == ST_DONE);
            // [R7] sticky until next sweep start
            ABORTED_O    <= ab_nxt | (ABORTED_O & ~sp.load);
        end
    end

    // [R20] done lasts one cycle
    property p_done_pulse;
        @(posedge CLK_I) disable iff (SRST_I) DONE_O |=> !DONE_O;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not one cycle"); // [R20]
    property p_apply_meas;
        @(posedge CLK_I) disable iff (SRST_I) MEAS_START_O |-> !SRC_APPLY_O;
    endproperty
    a_apply_meas: assert property (p_apply_meas) else $error("apply with measure"); // [R3]
    property p_buf;
        @(posedge CLK_I) disable iff (SRST_I)
            (st_r == ST_MEAS && MEAS_DONE_I) |=> BUF_WR_O && BUF_DATA_O == $past(MEAS_VAL_I);
    endproperty
    a_buf: assert property (p_buf) else $error("reading not buffered"); // [R17]
    property p_wrap;
        @(posedge CLK_I) disable iff (SRST_I)
            (st_r == ST_NEXT && !is_last && loc_r == 7'(MEM_LOCS) && !(br != '0 && LIMIT_PASS_I)
             && !restore) |=> loc_r == 7'h01;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap to one"); // [R11]
    property p_hold;
        @(posedge CLK_I) disable iff (SRST_I) HOLDOFF_O |-> styp_r == SW_MEM;
    endproperty
    a_hold: assert property (p_hold) else $error("holdoff outside stored sweep"); // [R13]
    property p_dly;
        @(posedge CLK_I) disable iff (SRST_I) (st_r != ST_IDLE) |=> $stable(sdly_r);
    endproperty
    a_dly: assert property (p_dly) else $error("delay changed mid sweep"); // [R4]
    property p_never;
        @(posedge CLK_I) disable iff (SRST_I) (sab_r == AB_NEVER && st_r != ST_IDLE) |-> !ab_nxt;
    endproperty
    a_never: assert property (p_never) else $error("abort in never mode"); // [R7]
    property p_early;
        @(posedge CLK_I) disable iff (SRST_I)
            (st_r == ST_DELAY && first_r && sab_r == AB_EARLY && compl_s[1]) |=> DONE_O && ABORTED_O;
    endproperty
    a_early: assert property (p_early) else $error("early abort missed"); // [R8]
    c_done:  cover property (@(posedge CLK_I) DONE_O && !ABORTED_O);
    c_abort: cover property (@(posedge CLK_I) DONE_O && ABORTED_O);
    c_wrap:  cover property (@(posedge CLK_I) st_r == ST_NEXT && loc_r == 7'(MEM_LOCS));
endmodule // sweep_seq

/* tb/meas_model.sv */
// measurement engine model answering each measurement start
`timescale 1ns/1ps
module meas_model
    import sweep_seq_pkg::*;
#(
    parameter int LAT = 3
)
(
    input  wire logic             clk_i,
    input  wire logic             start_i,
    input  wire logic [LVL_W-1:0] level_i,
    input  wire logic             compl_i,
    input  wire logic             pass_i,
    output logic                  done_o,
    output logic [LVL_W-1:0]      val_o,
    output logic                  compl_o,
    output logic                  pass_o
);
    int cnt = 0;
    initial done_o = 1'b0;
    initial val_o = '0;
    // reading after LAT cycles; value flips when not valid so stale data shows
    always @(posedge clk_i) begin
        done_o <= (cnt == 1);
        val_o  <= (cnt == 1) ? level_i : ~val_o;
        cnt    <= start_i ? LAT : ((cnt > 0) ? cnt - 1 : 0);
    end
    // compliance and limit result are levels set by the bench
    assign compl_o = compl_i;
    assign pass_o  = pass_i;
endmodule // meas_model

/* tb/tb_top.sv */
// self-checking bench for the sweep sequencer
`timescale 1ns/1ps
module tb_top;
    import sweep_seq_pkg::*;
    logic             CLK_I = 0, SRST_I = 1, WR_I = 0, RD_I = 0, TRIG_I = 0;
    logic             SETUP_WR_I = 0, compl_en = 0, pass_en = 0;
    logic [7:0]       ADDR_I = '0;
    logic [6:0]       SETUP_LOC_I = '0;
    logic [31:0]      WDATA_I = '0, SETUP_DATA_I = '0, RDATA_O, SETUP_O;
    logic             COMPL_I, MEAS_DONE_I, LIMIT_PASS_I, LEVEL_LOG_O, SRC_APPLY_O;
    logic             HOLDOFF_O, MEAS_START_O, BUF_WR_O, BUSY_O, DONE_O, ABORTED_O;
    logic [LVL_W-1:0] MEAS_VAL_I, LEVEL_O, BUF_DATA_O;
    logic [LVL_W-1:0] lv_q[$], su_q[$];
    int               mismatches = 0, tests_run = 0, bufs = 0, cyc = 0;
    logic             hold_seen = 0;
    sweep_seq dut (.*);
    meas_model #(.LAT(3)) mm (.clk_i(CLK_I), .start_i(MEAS_START_O), .level_i(LEVEL_O),
        .compl_i(compl_en), .pass_i(pass_en), .done_o(MEAS_DONE_I), .val_o(MEAS_VAL_I),
        .compl_o(COMPL_I), .pass_o(LIMIT_PASS_I));
    // 100 MHz clock
    initial forever #5 CLK_I = ~CLK_I;
    // record applied levels, buffer writes and holdoff; cut a hang short
    always @(posedge CLK_I) begin
        cyc++;
        if (SRC_APPLY_O) lv_q.push_back(LEVEL_O);
        if (SRC_APPLY_O) su_q.push_back(SETUP_O[23:0]);
        if (BUF_WR_O) bufs++;
        if (HOLDOFF_O) hold_seen = 1'b1;
        if (cyc == 40000) begin
            mismatches++;
            wrap_up;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_I) begin ADDR_I <= a; WDATA_I <= d; WR_I <= 1'b1; end
        @(posedge CLK_I) WR_I <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge CLK_I) begin ADDR_I <= a; RD_I <= 1'b1; end
        @(posedge CLK_I) RD_I <= 1'b0;
        #1 d = RDATA_O;
    endtask
    task automatic setup(input logic [6:0] l, input logic [31:0] d);
        @(posedge CLK_I) begin SETUP_LOC_I <= l; SETUP_DATA_I <= d; SETUP_WR_I <= 1'b1; end
        @(posedge CLK_I) SETUP_WR_I <= 1'b0;
    endtask
    // arm, trigger and wait for the completion pulse
    task automatic run(input logic [31:0] ctl);
        int n;
        lv_q = {};
        su_q = {};
        bufs = 0;
        hold_seen = 0;
        n = 0;
        wr(A_CTRL, ctl | 32'h0000_0010);
        @(posedge CLK_I) TRIG_I <= 1'b1;
        while (DONE_O !== 1'b1 && n < 3000) begin
            @(posedge CLK_I);
            #1 n++;
        end
        chk("done_seen", 1, n < 3000);
        @(posedge CLK_I) TRIG_I <= 1'b0;
        repeat (3) @(posedge CLK_I);
        #1 chk("busy_after", 0, BUSY_O);
    endtask
    task automatic t_reset;
        logic [31:0] d;
        rd(A_POINTS, d);
        chk("points_rst", 1, d);
        rd(A_MEMLOC, d);
        chk("memloc_rst", 1, d);
        rd(8'hFF, d);
        chk("unmapped", 0, d);
    endtask
    // staircase 10..40 by 10 under each abort mode
    task automatic t_lin(input logic [1:0] ab, input logic cp);
        logic [31:0] d;
        compl_en = cp;
        wr(A_START, 32'h0000_000A);
        wr(A_STOP, 32'h0000_0028);
        wr(A_STEP, 32'h0000_000A);
        wr(A_POINTS, 32'h0000_0004);
        wr(A_DELAY, 32'h0000_0002);
        run({28'h0, ab, 2'h0});
        compl_en = 0;
        // aborted flag stays set after the sweep, done and busy are clear
        rd(A_STATUS, d);
        chk("status", {29'h0000_0000, cp && ab != AB_NEVER, 2'b00}, d);
        if (cp && ab != AB_NEVER) begin
            chk("aborted", 1, ABORTED_O);
            chk("abort_bufs", (ab == AB_EARLY) ? 0 : 1, bufs);
        end else begin
            chk("aborted", 0, ABORTED_O);
            chk("lin_pts", 4, lv_q.size());
            for (int i = 0; i < 4; i++) chk("lin_lvl", 10 * (i + 1), lv_q[i]);
            chk("lin_bufs", 4, bufs);
            chk("lin_flag", 0, LEVEL_LOG_O);
        end
    endtask
    // log2 codes 0 to 2.0 over five points: quarter-span steps, last on stop
    task automatic t_log;
        wr(A_START, 32'h0000_0000);
        wr(A_STOP, 32'h0002_0000);
        wr(A_POINTS, 32'h0000_0005);
        run({30'h0, SW_LOG});
        chk("log_pts", 5, lv_q.size());
        for (int i = 0; i < 5; i++) chk("log_lvl", i * (32'h0002_0000 / 4), lv_q[i]);
        chk("log_flag", 1, LEVEL_LOG_O);
    endtask
    task automatic t_cust;
        wr(A_CUSTIDX, 32'h0000_0000);
        wr(A_CUSTVAL, 32'h0000_0005);
        wr(A_CUSTVAL, 32'h0000_0007);
        wr(A_CUSTVAL, 32'h0000_0003);
        wr(A_POINTS, 32'h0000_0003);
        run({30'h0, SW_CUST});
        chk("cust_pts", 3, lv_q.size());
        chk("cust_0", 5, lv_q[0]);
        chk("cust_1", 7, lv_q[1]);
        chk("cust_2", 3, lv_q[2]);
    endtask
    // start 99, wrap past 100, branch 1 to 3 on pass, holdoff at 3
    task automatic t_mem;
        setup(7'h63, 32'h0000_0063);
        setup(7'h64, 32'h0000_0064);
        setup(7'h01, 32'h0600_0001);
        setup(7'h03, 32'h0100_0003);
        wr(A_MEMLOC, 32'h0000_0063);
        wr(A_POINTS, 32'h0000_0004);
        pass_en = 1;
        run({30'h0, SW_MEM});
        pass_en = 0;
        chk("mem_pts", 4, su_q.size());
        chk("mem_0", 32'h63, su_q[0]);
        chk("mem_1", 32'h64, su_q[1]);
        chk("mem_2", 32'h01, su_q[2]);
        chk("mem_3", 32'h03, su_q[3]);
        chk("holdoff", 1, hold_seen);
        // single restore of location 1 puts its whole setup word out
        wr(A_RESTORE, 32'h0000_0001);
        #1 chk("restore", 32'h0600_0001, SETUP_O);
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // main sequence after 12 reset cycles
    initial begin
        repeat (12) @(posedge CLK_I);
        SRST_I <= 1'b0;
        t_reset;
        t_lin(AB_NEVER, 0);
        for (int m = 0; m < 3; m++) t_lin(m[1:0], 1);
        t_log;
        t_cust;
        t_mem;
        wrap_up;
    end
endmodule // tb_top
